// ==== ec_host_model.sv ====
// Host model: APB master that issues register transfers to the bank.
// Assumes pclk from the bench; the bench calls its tasks.
`timescale 1ns/1ps
`default_nettype none
module ec_host_model (
  input wire logic pclk,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [ec_pair_pkg::ADDR_W-1:0] paddr,
  output var logic [31:0] pwdata,
  output var logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import ec_pair_pkg::*;
  initial begin
    {psel, penable, pwrite} = 3'h0;
    {paddr, pwdata} = '0;
    pstrb = 4'h1;
  end
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      echo_canceller_channel_ctrl_test.err_count++;
      echo_canceller_channel_ctrl_test.final_report();
    end
  endtask
  // Second canceller controls take an identical pair of writes
  task automatic dbl(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
    repeat (100) @(posedge pclk);
    xfer(1'b1, a, d, q, e);
  endtask
endmodule // ec_host_model
`default_nettype wire

// ==== ec_pair_ctrl.sv ====
// Control and status register bank of one canceller pair, with APB slave.
// Assumes APB master on pclk; detector flags arrive synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none

module echo_canceller_channel_ctrl #(
  parameter int INIT_LEN = ec_pair_pkg::INIT_CYCLES,
  parameter int GAP_MAX = ec_pair_pkg::DUP_GAP_MAX_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ec_pair_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] tone_detected,
  input wire logic [1:0] double_talk_in,
  input wire logic [1:0] rin_above_threshold,
  input wire logic [1:0] narrowband_in,
  output logic init_busy,
  output logic [1:0] coeff_clear,
  output logic [1:0] noise_inject_on,
  output logic [1:0] back_to_back_topology,
  output logic [1:0] rin_pad_12db,
  output logic [1:0] path_bypass,
  output logic [1:0] adapt_run,
  output logic [1:0] echo_cancel_on,
  output logic cascade_long_tail,
  output logic [1:0] tone_detect_on,
  output logic tone_proc_power_down,
  output logic [1:0] phase_reversal_ignore,
  output logic [1:0] nonlinear_proc_on,
  output logic [1:0] auto_tone_bypass,
  output logic [1:0] narrowband_detect_on,
  output logic [1:0] offset_filter_on,
  output logic [1:0] send_out_silence,
  output logic [1:0] receive_out_silence
);
  import ec_pair_pkg::*;

  localparam logic [INIT_CNT_W-1:0] INIT_LAST =
    INIT_CNT_W'(INIT_LEN - 1);
  localparam logic [GAP_CNT_W-1:0] GAP_LO = GAP_CNT_W'(DUP_GAP_MIN_CYCLES);
  localparam logic [GAP_CNT_W-1:0] GAP_HI = GAP_CNT_W'(GAP_MAX);

  typedef struct packed {
    logic [1:0][7:0] ctrl_one;
    logic [1:0][7:0] ctrl_two;
    logic init;
    logic [INIT_CNT_W-1:0] init_cnt;
    logic dup_pending;
    logic dup_is_two;
    logic [7:0] dup_data;
    logic [GAP_CNT_W-1:0] dup_gap;
    logic [31:0] rdata;
  } state_s;

  state_s st_q;
  state_s st_d;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic [7:0] idx;
  logic mapped;
  logic setup_ph;
  logic access_ph;
  logic wr_now;
  logic [7:0] wbyte;
  logic [1:0][7:0] status;
  logic [1:0] tone_seen;

  assign idx = paddr[ADDR_W-1:2];
  assign mapped = (paddr[1:0] == 2'h0) &&
    (idx == IDX_FIRST_CTRL_ONE || idx == IDX_FIRST_CTRL_TWO ||
     idx == IDX_FIRST_STATUS || idx == IDX_SECOND_CTRL_ONE ||
     idx == IDX_SECOND_CTRL_TWO || idx == IDX_SECOND_STATUS);
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_now = access_ph && pwrite && mapped && pstrb[0];
  assign wbyte = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Status composition
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      tone_seen[c] = tone_detected[c] &&
        !st_q.ctrl_two[c][C2_TONE_DETECT_OFF];
      status[c] = 8'h00;
      status[c][ST_TONE] = tone_seen[c];
      status[c][ST_DOUBLE_TALK] = double_talk_in[c];
      status[c][ST_ACTIVE] = rin_above_threshold[c];
      status[c][ST_GATED_TONE] = tone_seen[c] &&
        st_q.ctrl_two[c][C2_AUTO_TONE_BYPASS];
      status[c][ST_NARROWBAND] = narrowband_in[c] &&
        !st_q.ctrl_two[c][C2_NARROWBAND_OFF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d = st_q;

    // Read data captured in the setup phase, shown in the access phase
    if (setup_ph) begin
      st_d.rdata = 32'h0000_0000;
      if (!pwrite && paddr[1:0] == 2'h0) begin
        case (idx)
          IDX_FIRST_CTRL_ONE: st_d.rdata[7:0] = st_q.ctrl_one[0];
          IDX_FIRST_CTRL_TWO: st_d.rdata[7:0] = st_q.ctrl_two[0];
          IDX_FIRST_STATUS: st_d.rdata[7:0] = status[0];
          IDX_SECOND_CTRL_ONE: st_d.rdata[7:0] = st_q.ctrl_one[1];
          IDX_SECOND_CTRL_TWO: st_d.rdata[7:0] = st_q.ctrl_two[1];
          IDX_SECOND_STATUS: st_d.rdata[7:0] = status[1];
          default: st_d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Duplicate-write window timer for the second canceller
    if (st_q.dup_pending) begin
      if (st_q.dup_gap >= GAP_HI) begin
        st_d.dup_pending = 1'b0;
      end else begin
        st_d.dup_gap = st_q.dup_gap + GAP_CNT_W'(1);
      end
    end

    if (st_q.init) begin
      // Writes are dropped until the pair is initialized
      if (st_q.init_cnt == INIT_LAST) begin
        st_d.init = 1'b0;
        st_d.init_cnt = '0;
      end else begin
        st_d.init_cnt = st_q.init_cnt + INIT_CNT_W'(1);
      end
    end else if (wr_now) begin
      case (idx)
        IDX_FIRST_CTRL_ONE: st_d.ctrl_one[0] = wbyte;
        IDX_FIRST_CTRL_TWO: st_d.ctrl_two[0] = wbyte;
        IDX_SECOND_CTRL_ONE, IDX_SECOND_CTRL_TWO: begin
          if (st_q.dup_pending &&
              st_q.dup_is_two == (idx == IDX_SECOND_CTRL_TWO) &&
              st_q.dup_data == wbyte && st_q.dup_gap >= GAP_LO &&
              st_q.dup_gap <= GAP_HI) begin
            if (idx == IDX_SECOND_CTRL_TWO) begin
              st_d.ctrl_two[1] = wbyte;
            end else begin
              st_d.ctrl_one[1] = wbyte;
            end
            st_d.dup_pending = 1'b0;
          end else begin
            st_d.dup_pending = 1'b1;
            st_d.dup_is_two = (idx == IDX_SECOND_CTRL_TWO);
            st_d.dup_data = wbyte;
            st_d.dup_gap = '0;
          end
        end
        default: st_d.dup_is_two = st_d.dup_is_two;
      endcase
    end

    // Init bit committed: restore defaults, including the bit itself
    if (!st_q.init &&
        (st_d.ctrl_one[0][C1_INIT] || st_d.ctrl_one[1][C1_INIT])) begin
      st_d.init = 1'b1;
      st_d.init_cnt = '0;
      st_d.ctrl_one[0] = RST_FIRST_CTRL_ONE;
      st_d.ctrl_one[1] = RST_SECOND_CTRL_ONE;
      st_d.ctrl_two[0] = RST_CTRL_TWO;
      st_d.ctrl_two[1] = RST_CTRL_TWO;
      st_d.dup_pending = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.ctrl_one[0] <= RST_FIRST_CTRL_ONE;
      st_q.ctrl_one[1] <= RST_SECOND_CTRL_ONE;
      st_q.ctrl_two[0] <= RST_CTRL_TWO;
      st_q.ctrl_two[1] <= RST_CTRL_TWO;
      st_q.init <= 1'b0;
      st_q.init_cnt <= '0;
      st_q.dup_pending <= 1'b0;
      st_q.dup_is_two <= 1'b0;
      st_q.dup_data <= 8'h00;
      st_q.dup_gap <= '0;
      st_q.rdata <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answers
  assign pready = 1'b1;
  assign pslverr = access_ph && !mapped;
  assign prdata = st_q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Canceller controls
  assign init_busy = st_q.init;
  assign cascade_long_tail = st_q.ctrl_one[0][C1_CASCADE];
  assign tone_proc_power_down = st_q.ctrl_two[0][C2_TONE_DETECT_OFF] &&
    st_q.ctrl_two[1][C2_TONE_DETECT_OFF];

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      noise_inject_on[c] = !st_q.ctrl_one[c][C1_NOISE_INJECT_OFF];
      back_to_back_topology[c] = st_q.ctrl_one[c][C1_BACK_TO_BACK];
      rin_pad_12db[c] = st_q.ctrl_one[c][C1_PAD];
      auto_tone_bypass[c] = st_q.ctrl_two[c][C2_AUTO_TONE_BYPASS];
      path_bypass[c] = st_q.ctrl_one[c][C1_BYPASS] ||
        (auto_tone_bypass[c] && tone_seen[c]);
      coeff_clear[c] = st_q.init || st_q.ctrl_one[c][C1_BYPASS];
      echo_cancel_on[c] = !path_bypass[c] && !st_q.init;
      adapt_run[c] = echo_cancel_on[c] &&
        !st_q.ctrl_one[c][C1_ADAPT_FREEZE];
      tone_detect_on[c] = !st_q.ctrl_two[c][C2_TONE_DETECT_OFF];
      phase_reversal_ignore[c] =
        st_q.ctrl_two[c][C2_PHASE_REV_IGNORE];
      nonlinear_proc_on[c] = !st_q.ctrl_two[c][C2_NONLINEAR_OFF];
      narrowband_detect_on[c] =
        !st_q.ctrl_two[c][C2_NARROWBAND_OFF];
      offset_filter_on[c] = !st_q.ctrl_two[c][C2_OFFSET_FILTER_SKIP];
      send_out_silence[c] = st_q.ctrl_two[c][C2_SEND_SILENCE];
      receive_out_silence[c] = st_q.ctrl_two[c][C2_RECEIVE_SILENCE];
    end
  end

endmodule // echo_canceller_channel_ctrl

`default_nettype wire

// ==== ec_pair_monitor.sv ====
// Checker for the canceller pair register bank outputs and first canceller status reads.
// Bound to the bank; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ec_pair_monitor import ec_pair_pkg::*; #(
  parameter int INIT_LEN = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ec_pair_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [1:0] tone_detected,
  input wire logic [1:0] double_talk_in,
  input wire logic [1:0] rin_above_threshold,
  input wire logic [1:0] narrowband_in,
  input wire logic init_busy,
  input wire logic [1:0] noise_inject_on,
  input wire logic [1:0] send_out_silence,
  input wire logic [1:0] path_bypass,
  input wire logic [1:0] adapt_run,
  input wire logic [1:0] echo_cancel_on,
  input wire logic [1:0] tone_detect_on,
  input wire logic tone_proc_power_down,
  input wire logic [1:0] auto_tone_bypass,
  input wire logic [1:0] narrowband_detect_on
);
  import ec_pair_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [16:0] busy_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_q <= '0;
    else busy_q <= init_busy ? busy_q + 17'h1 : '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence st_rd;
    psel && !penable && !pwrite && paddr == {IDX_FIRST_STATUS, 2'b00};
  endsequence
  sequence st_acc;
    ##1 psel && penable;
  endsequence
  chk_status_tone_talk: assert property (st_rd ##0 st_acc |->
    prdata[6:5] == $past({tone_detected[0] & tone_detect_on[0],
    double_talk_in[0]})) else $error("status tone or talk bit wrong");
  chk_status_active: assert property (st_rd ##0 st_acc |->
    prdata[ST_ACTIVE] == $past(rin_above_threshold[0]))
    else $error("status activity bit wrong");
  chk_status_gated: assert property (st_rd ##0 st_acc |->
    prdata[ST_GATED_TONE] == $past(tone_detected[0] & tone_detect_on[0]
    & auto_tone_bypass[0])) else $error("status gated tone bit wrong");
  chk_status_narrow: assert property (st_rd ##0 st_acc |->
    prdata[ST_NARROWBAND] == $past(narrowband_in[0]
    & narrowband_detect_on[0])) else $error("status narrowband bit wrong");
  chk_status_reserved: assert property (st_rd ##0 st_acc |->
    {prdata[31:7], prdata[4:3]} == '0) else $error("reserved bits set");
  chk_bypass_halts: assert property (
    (path_bypass & (echo_cancel_on | adapt_run)) == 2'b00)
    else $error("bypass with cancel or adaptation running");
  chk_adapt_needs_cancel: assert property (
    (adapt_run & ~echo_cancel_on) == 2'b00)
    else $error("adaptation without cancelling");
  chk_tone_power: assert property (
    tone_proc_power_down == (tone_detect_on == 2'b00))
    else $error("tone power down wrong");
  chk_auto_bypass: assert property (auto_tone_bypass[0] &&
    tone_detected[0] && tone_detect_on[0] |-> ##[0:2] path_bypass[0])
    else $error("no automatic tone bypass");
  chk_init_defaults: assert property ($rose(init_busy) |->
    noise_inject_on == 2'b11 && send_out_silence == 2'b00)
    else $error("init did not restore defaults");
  chk_init_length: assert property ($fell(init_busy) |->
    busy_q == INIT_LEN) else $error("init length wrong");
  chk_init_bound: assert property (busy_q <= INIT_LEN)
    else $error("init too long");
endmodule // ec_pair_monitor
bind echo_canceller_channel_ctrl ec_pair_monitor #(.INIT_LEN(INIT_LEN))
  ec_pair_monitor_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .tone_detected, .double_talk_in, .rin_above_threshold,
  .narrowband_in, .init_busy, .noise_inject_on, .send_out_silence,
  .path_bypass, .adapt_run, .echo_cancel_on, .tone_detect_on,
  .tone_proc_power_down, .auto_tone_bypass, .narrowband_detect_on);
`default_nettype wire

// ==== ec_pair_pkg.sv ====
// Constants, register map and field layout of the canceller pair controls.
// Assumes a 250 MHz pclk and an APB master with 32-bit data.

package ec_pair_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FIRST_CTRL_ONE = 8'h00;
  localparam logic [7:0] IDX_FIRST_CTRL_TWO = 8'h01;
  localparam logic [7:0] IDX_FIRST_STATUS = 8'h02;
  localparam logic [7:0] IDX_SECOND_CTRL_ONE = 8'h20;
  localparam logic [7:0] IDX_SECOND_CTRL_TWO = 8'h21;
  localparam logic [7:0] IDX_SECOND_STATUS = 8'h22;
  localparam int ADDR_W = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_FIRST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_SECOND_CTRL_ONE = 8'h02;
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Control one fields
  localparam int C1_INIT = 7;
  localparam int C1_NOISE_INJECT_OFF = 6;
  localparam int C1_BACK_TO_BACK = 5;
  localparam int C1_PAD = 4;
  localparam int C1_BYPASS = 3;
  localparam int C1_ADAPT_FREEZE = 2;
  localparam int C1_CASCADE = 0;

  // Control two fields
  localparam int C2_TONE_DETECT_OFF = 7;
  localparam int C2_PHASE_REV_IGNORE = 6;
  localparam int C2_NONLINEAR_OFF = 5;
  localparam int C2_AUTO_TONE_BYPASS = 4;
  localparam int C2_NARROWBAND_OFF = 3;
  localparam int C2_OFFSET_FILTER_SKIP = 2;
  localparam int C2_SEND_SILENCE = 1;
  localparam int C2_RECEIVE_SILENCE = 0;

  // Status fields
  localparam int ST_TONE = 6;
  localparam int ST_DOUBLE_TALK = 5;
  localparam int ST_ACTIVE = 2;
  localparam int ST_GATED_TONE = 1;
  localparam int ST_NARROWBAND = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int FRAME_NS = 125000;
  localparam int INIT_FRAMES = 2;
  localparam int INIT_CYCLES = INIT_FRAMES * FRAME_NS * CLK_MHZ / 1000;
  localparam int DUP_GAP_MIN_NS = 350;
  localparam int DUP_GAP_MAX_NS = 20000;
  localparam int DUP_GAP_MIN_CYCLES = (DUP_GAP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int DUP_GAP_MAX_CYCLES = DUP_GAP_MAX_NS * CLK_MHZ / 1000;
  localparam int INIT_CNT_W = 17;
  localparam int GAP_CNT_W = 14;

endpackage

// ==== echo_canceller_channel_ctrl_test.sv ====
// Testbench of the canceller pair register bank, driven by the host model.
// Assumes shortened init and gap parameters set below.
`timescale 1ns/1ps
`default_nettype none
module echo_canceller_channel_ctrl_test;
  import ec_pair_pkg::*;
  localparam logic [9:0] A1 = 10'h000, A2 = 10'h004, AS = 10'h008;
  localparam logic [9:0] B1 = 10'h080, B2 = 10'h084, BS = 10'h088;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, init_busy;
  logic cascade_long_tail, tone_proc_power_down, e;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] q;
  logic [1:0] tone_detected = 2'h0, double_talk_in = 2'h0;
  logic [1:0] rin_above_threshold = 2'h0, narrowband_in = 2'h0;
  logic [1:0] coeff_clear, noise_inject_on, back_to_back_topology;
  logic [1:0] rin_pad_12db, path_bypass, adapt_run, echo_cancel_on;
  logic [1:0] tone_detect_on, phase_reversal_ignore, nonlinear_proc_on;
  logic [1:0] auto_tone_bypass, narrowband_detect_on, offset_filter_on;
  logic [1:0] send_out_silence, receive_out_silence;
  int err_count = 0, checks = 0;
  always #2 pclk = ~pclk;
  echo_canceller_channel_ctrl #(.INIT_LEN(20), .GAP_MAX(200))
    echo_canceller_channel_ctrl_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .tone_detected, .double_talk_in, .rin_above_threshold, .narrowband_in,
    .init_busy, .coeff_clear, .noise_inject_on, .back_to_back_topology,
    .rin_pad_12db, .path_bypass, .adapt_run, .echo_cancel_on,
    .cascade_long_tail, .tone_detect_on, .tone_proc_power_down,
    .phase_reversal_ignore, .nonlinear_proc_on, .auto_tone_bypass,
    .narrowband_detect_on, .offset_filter_on, .send_out_silence,
    .receive_out_silence);
  ec_host_model ec_host_model_i (.pclk, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr);
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string n, input logic [7:0] x, input logic [7:0] g);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    ec_host_model_i.xfer(1'b1, a, d, q, e);
    @(negedge pclk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] x);
    ec_host_model_i.xfer(1'b0, a, 8'h00, q, e);
    cmp("read data", x, q);
  endtask
  task automatic t_reset;
    rd(A1, 8'h00);
    rd(A2, 8'h00);
    rd(B1, 8'h02);
    rd(B2, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_ctrl_one;
    wr(A1, 8'h5c);
    cmp("noise", 8'h02, {6'h0, noise_inject_on});
    cmp("pad", 8'h01, {6'h0, rin_pad_12db});
    cmp("bypass", 8'h05, {4'h0, path_bypass, coeff_clear});
    cmp("run", 8'h0a, {4'h0, adapt_run, echo_cancel_on});
    wr(A1, 8'h04);
    cmp("freeze", 8'h0b, {4'h0, adapt_run, echo_cancel_on});
    wr(A1, 8'h01);
    cmp("cascade", 8'h01, {7'h0, cascade_long_tail});
    wr(A1, 8'h20);
    ec_host_model_i.dbl(B1, 8'h22);
    @(negedge pclk);
    cmp("topology", 8'h03, {5'h0, cascade_long_tail,
      back_to_back_topology});
    $display("test control one done");
  endtask
  task automatic t_ctrl_two;
    wr(A2, 8'hff);
    cmp("ctl2 set", 8'h53, {tone_detect_on[0], phase_reversal_ignore[0],
      nonlinear_proc_on[0], auto_tone_bypass[0], narrowband_detect_on[0],
      offset_filter_on[0], send_out_silence[0],
      receive_out_silence[0]});
    wr(A2, 8'h00);
    cmp("ctl2 clr", 8'hac, {tone_detect_on[0], phase_reversal_ignore[0],
      nonlinear_proc_on[0], auto_tone_bypass[0], narrowband_detect_on[0],
      offset_filter_on[0], send_out_silence[0],
      receive_out_silence[0]});
    wr(B2, 8'h81);
    rd(B2, 8'h00);
    repeat (100) @(posedge pclk);
    wr(B2, 8'h81);
    rd(B2, 8'h81);
    wr(A2, 8'h90);
    cmp("power down", 8'h01, {7'h0, tone_proc_power_down});
    $display("test control two done");
  endtask
  task automatic t_status;
    wr(A2, 8'h10);
    tone_detected <= 2'h3;
    double_talk_in <= 2'h3;
    rin_above_threshold <= 2'h3;
    narrowband_in <= 2'h3;
    rd(AS, 8'h67);
    rd(BS, 8'h25);
    cmp("auto bypass", 8'h01, {6'h0, path_bypass});
    wr(AS, 8'h00);
    rd(AS, 8'h67);
    ec_host_model_i.xfer(1'b0, 10'h00c, 8'h00, q, e);
    cmp("unmapped", 8'h01, {7'h0, e});
    tone_detected <= 2'h0;
    $display("test status done");
  endtask
  task automatic t_init;
    int n;
    wr(A1, 8'h80);
    cmp("busy", 8'h01, {7'h0, init_busy});
    wr(A2, 8'h0f);
    for (n = 0; n < 40 && init_busy !== 1'b0; n++) @(negedge pclk);
    if (n >= 40) begin
      err_count++;
      final_report();
    end
    rd(A1, 8'h00);
    rd(A2, 8'h00);
    rd(B1, 8'h02);
    rd(B2, 8'h00);
    $display("test init done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ctrl_one();
    t_ctrl_two();
    t_status();
    t_init();
    final_report();
  end
endmodule // echo_canceller_channel_ctrl_test
`default_nettype wire
